// >>> design/sfpi_pkg.sv
// Shared constants for the serial flash pin interface.
package sfpi_pkg;

  // Bits in one transfer unit on the serial and parallel paths.
  localparam int unsigned BYTE_BITS = 8;

  // Width of the bit counter that walks one serial byte.
  localparam int unsigned BIT_CNT_W = 3;

  // Last bit index of a serial byte, sized for the bit counter.
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Counter value at a byte boundary.
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // Depth of each crossing buffer, in bytes.
  localparam int unsigned FIFO_DEPTH = 4;

  // Byte shifted out when software has queued nothing to send.
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  // Reset value of the outgoing shift register.
  localparam logic [7:0] SHIFT_RESET = 8'hff;

  // Reset value of the incoming shift register.
  localparam logic [7:0] SHIFT_IN_RESET = 8'h00;

  // Fill bit shifted in behind the outgoing byte.
  localparam logic FILL_BIT = 1'b1;

  // Clock period of the system domain in nanoseconds.
  localparam int unsigned CLOCK_PERIOD_NS = 100;

endpackage

// >>> design/sfpi_pin_interface.sv
// Serial flash pin front end: link-side shifters, crossing buffers and system-side status.
//
// Operation
// - Serial output bits change after falling clock edges.
// - Parallel port: sample rising, drive after falling.
// - Capture serial input bits on rising edges.
// - Select low means selected and active.
// - Select high: deselected, serial output floats.
// - Ignore commands until first select falling edge.
// - Standby when deselected and no operation busy.
// - Pause suspends the exchange, resumes later.
// - Pause low: output floats, inputs ignored.
// - Protect low blocks writes to protected area.
// - Elevated voltage selects accelerated programming mode.
// - Works with clock modes zero and three.
// - All transfers are whole eight-bit bytes.

`timescale 1ns/100ps

// Dual-clock FIFO: gray-coded pointers cross between the write and read domains.
module sfpi_async_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = sfpi_pkg::FIFO_DEPTH
) (
  input  wire logic             wrClock,  // Write-side clock.
  input  wire logic             wrRst,    // Write-side synchronous reset.
  input  wire logic             wrValid,  // Write request.
  output logic                  wrReady,  // Room for one more word.
  input  wire logic [WIDTH-1:0] wrData,   // Word to store.
  input  wire logic             rdClock,  // Read-side clock.
  input  wire logic             rdRst,    // Read-side synchronous reset.
  output logic                  rdValid,  // A word is waiting.
  input  wire logic             rdReady,  // Read acknowledge.
  output logic [WIDTH-1:0]      rdData    // Word at the head.
);
  localparam int unsigned AW = $clog2(DEPTH);

  // Gray pointers need a power-of-two depth of at least two.
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("FIFO depth must be a power of two, at least two.");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];       // Storage, written only in the write domain.
  logic [AW:0]      wrBin;             // Write pointer, binary.
  logic [AW:0]      wrGray;            // Write pointer, gray.
  logic [AW:0]      rdBin;             // Read pointer, binary.
  logic [AW:0]      rdGray;            // Read pointer, gray.
  logic [AW:0]      rdGraySync1;       // Read pointer, first sync stage.
  logic [AW:0]      rdGraySync2;       // Read pointer in the write domain.
  logic [AW:0]      wrGraySync1;       // Write pointer, first sync stage.
  logic [AW:0]      wrGraySync2;       // Write pointer in the read domain.
  wire  [AW:0]      next_wrBin = wrBin + 1'b1;
  wire  [AW:0]      next_rdBin = rdBin + 1'b1;
  wire              wrFire     = wrValid & wrReady;
  wire              rdFire     = rdValid & rdReady;
  wire  [AW:0]      fullMatch  = {~rdGraySync2[AW:AW-1], rdGraySync2[AW-2:0]};

  // Full when the write pointer laps the synchronised read pointer.
  assign wrReady = (wrGray != fullMatch);
  // Empty when both pointers agree; this reads late, never early.
  assign rdValid = (rdGray != wrGraySync2);
  assign rdData  = mem[rdBin[AW-1:0]];

  // Write side: store the word; the pointer advances in the next block.
  always_ff @(posedge wrClock) begin
    if (wrFire) begin
      mem[wrBin[AW-1:0]] <= wrData;
    end
  end

  // Write pointer and the read pointer's synchroniser.
  always_ff @(posedge wrClock) begin
    if (wrRst) begin
      wrBin       <= '0;
      wrGray      <= '0;
      rdGraySync1 <= '0;
      rdGraySync2 <= '0;
    end else begin
      rdGraySync1 <= rdGray;
      rdGraySync2 <= rdGraySync1;
      if (wrFire) begin
        wrBin  <= next_wrBin;
        wrGray <= next_wrBin ^ (next_wrBin >> 1);
      end
    end
  end

  // Read pointer and the write pointer's synchroniser.
  always_ff @(posedge rdClock) begin
    if (rdRst) begin
      rdBin       <= '0;
      rdGray      <= '0;
      wrGraySync1 <= '0;
      wrGraySync2 <= '0;
    end else begin
      wrGraySync1 <= wrGray;
      wrGraySync2 <= wrGraySync1;
      if (rdFire) begin
        rdBin  <= next_rdBin;
        rdGray <= next_rdBin ^ (next_rdBin >> 1);
      end
    end
  end
endmodule

// Top level: pins of the flash on one side, byte streams and status on the other.
module sfpi_pin_interface #(
  parameter int unsigned DEPTH = sfpi_pkg::FIFO_DEPTH
) (
  input  wire logic       clock,                   // System clock, 10 MHz.
  input  wire logic       rst,                     // Synchronous reset, active high.
  input  wire logic       serialClock,             // Link clock from the host.
  input  wire logic       selectN,                 // Chip select, active low.
  input  wire logic       serialIn,                // Serial data from the host.
  output logic            serialOut,               // Serial data to the host.
  output logic            serialOutOe,             // Drive enable of serialOut.
  input  wire logic       pauseN,                  // Pause input, active low.
  input  wire logic       protectBoostInputN,      // Write protect pin, active low.
  input  wire logic       elevatedProgramVoltage,  // Comparator: pin at boost level.
  input  wire logic       parallelMode,            // Use the eight-bit port.
  input  wire logic [7:0] parallelIoBusIn,         // Parallel port, pin level.
  output logic [7:0]      parallelIoBusOut,        // Parallel port, driven value.
  output logic            parallelIoBusOe,         // Drive enable of the port.
  output logic [7:0]      rxData,                  // Received byte.
  output logic            rxValid,                 // Received byte waiting.
  input  wire logic       rxReady,                 // Consumer takes rxData.
  input  wire logic [7:0] txData,                  // Byte to send.
  input  wire logic       txValid,                 // txData is offered.
  output logic            txReady,                 // Send buffer has room.
  output logic            rxOverrun,               // Sticky: a received byte was lost.
  output logic            selected,                // Device selected and active.
  output logic            standby,                 // Device in standby.
  input  wire logic       operationBusy,           // Program, erase or status write running.
  input  wire logic [2:0] blockProtectBits,        // Protected area selector.
  input  wire logic       targetInArea,            // Current target lies in that area.
  output logic            programBlocked,          // Program or erase must not alter data.
  output logic            accelProgram             // Accelerated programming selected.
);
  // Pointer logic needs a power-of-two depth; only the minimum of two is checked here, the buffer checks the power of two.
  initial begin
    if (DEPTH < 2) begin
      $error("Buffer depth must be at least two.");
    end
  end

  // ---------------- System domain ----------------

  logic       selSync1;       // Select, first sync stage.
  logic       selSync2;       // Select in the system domain.
  logic       selPrev;        // Select one cycle earlier.
  logic       armed;          // A select falling edge has been seen.
  logic       wpSync1;        // Protect pin, first sync stage.
  logic       wpSync2;        // Protect pin in the system domain.
  logic       hvSync1;        // Boost comparator, first sync stage.
  logic       hvSync2;        // Boost comparator in the system domain.
  logic       lostSync1;      // Overrun flag, first sync stage.
  logic       lostSync2;      // Overrun flag in the system domain.
  logic       linkRstSync1;   // Reset into the link domain, first stage.
  logic       linkRst;        // Reset in the link domain.
  logic       rxLost;         // Sticky: received byte found the buffer full.
  wire        selFall    = selPrev & ~selSync2;
  wire        areaActive = (blockProtectBits != 3'h0) & targetInArea;

  // Pin and overrun-flag synchronisers; only the second stage feeds logic.
  always_ff @(posedge clock) begin
    if (rst) begin
      selSync1  <= 1'b1;
      selSync2  <= 1'b1;
      selPrev   <= 1'b1;
      wpSync1   <= 1'b1;
      wpSync2   <= 1'b1;
      hvSync1   <= 1'b0;
      hvSync2   <= 1'b0;
      lostSync1 <= 1'b0;
      lostSync2 <= 1'b0;
    end else begin
      selSync1  <= selectN;
      selSync2  <= selSync1;
      selPrev   <= selSync2;
      wpSync1   <= protectBoostInputN;
      wpSync2   <= wpSync1;
      hvSync1   <= elevatedProgramVoltage;
      hvSync2   <= hvSync1;
      lostSync1 <= rxLost;
      lostSync2 <= lostSync1;
    end
  end

  // Commands count only after the first select falling edge since reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (selFall) begin
      armed <= 1'b1;
    end
  end

  // Status outputs, all registered.
  always_ff @(posedge clock) begin
    if (rst) begin
      selected       <= 1'b0;
      standby        <= 1'b1;
      programBlocked <= 1'b0;
      accelProgram   <= 1'b0;
      rxOverrun      <= 1'b0;
    end else begin
      selected       <= ~selSync2;
      // Deselected alone is not enough: a running write keeps power up.
      standby        <= selSync2 & ~operationBusy;
      programBlocked <= ~wpSync2 & areaActive;
      accelProgram   <= hvSync2;
      rxOverrun      <= lostSync2;
    end
  end

  // ---------------- Link domain ----------------

  logic       armSync1;       // Armed flag, first link sync stage.
  logic       armLink;        // Armed flag in the link domain.
  logic       parSync1;       // Parallel mode, first link sync stage.
  logic       parLink;        // Parallel mode in the link domain.
  logic [2:0] bitCnt;         // Rising edges seen in the current byte.
  logic [7:0] shiftIn;        // Incoming serial bits.
  logic [7:0] nextOut;        // Byte fetched for the next output slot.
  logic       nextReal;       // nextOut came from the send buffer.
  logic       byteToggle;     // Flips at each completed byte, rising side.
  logic       loadSeen;       // Last toggle value the falling side acted on.
  logic [7:0] shiftOut;       // Outgoing byte, MSB in front.
  logic       outReal;        // shiftOut holds a queued byte.
  logic       rxWrReady;      // Receive buffer has room.
  logic       txRdValid;      // Send buffer holds a byte.
  logic [7:0] txRdData;       // Head of the send buffer.

  // The link clock may stand still, so the link reset is only seen
  // while the host is clocking; selectN high clears the byte state anyway.
  always_ff @(posedge serialClock) begin
    linkRstSync1 <= rst;
    linkRst      <= linkRstSync1;
    armSync1     <= armed;
    armLink      <= armSync1;
    parSync1     <= parallelMode;
    parLink      <= parSync1;
  end

  wire linkActive   = ~selectN & pauseN & armLink;
  wire byteComplete = linkActive & (parLink | (bitCnt == sfpi_pkg::LAST_BIT));
  wire [7:0] rxByte = parLink ? parallelIoBusIn : {shiftIn[6:0], serialIn};
  wire loadNow      = (byteToggle != loadSeen) & pauseN;

  // Rising edge: capture input; select high clears the count at once.
  always_ff @(posedge serialClock or posedge selectN) begin
    if (selectN) begin
      bitCnt     <= sfpi_pkg::FIRST_BIT;
      shiftIn    <= sfpi_pkg::SHIFT_IN_RESET;
      byteToggle <= 1'b0;
    end else if (linkActive) begin
      // A paused clock leaves everything where it was, so the byte resumes.
      shiftIn <= {shiftIn[6:0], serialIn};
      bitCnt  <= parLink ? sfpi_pkg::FIRST_BIT : bitCnt + 3'h1;
      if (byteComplete) begin
        byteToggle <= ~byteToggle;
      end
    end
  end

  // Rising edge: fetch the byte for the next slot at each byte boundary.
  always_ff @(posedge serialClock) begin
    if (byteComplete) begin
      nextOut  <= txRdValid ? txRdData : sfpi_pkg::IDLE_BYTE;
      nextReal <= txRdValid;
    end
  end

  // Receive losses stay flagged until reset.
  always_ff @(posedge serialClock) begin
    if (linkRst) begin
      rxLost <= 1'b0;
    end else if (byteComplete & ~rxWrReady) begin
      rxLost <= 1'b1;
    end
  end

  // Falling edge: the same edge type serves clock modes zero and three,
  // because a load waits for a completed byte, not for the first edge.
  always_ff @(negedge serialClock or posedge selectN) begin
    if (selectN) begin
      shiftOut <= sfpi_pkg::SHIFT_RESET;
      outReal  <= 1'b0;
      loadSeen <= 1'b0;
    end else if (loadNow) begin
      shiftOut <= nextOut;
      outReal  <= nextReal;
      loadSeen <= byteToggle;
    end else if (pauseN) begin
      shiftOut <= {shiftOut[6:0], sfpi_pkg::FILL_BIT};
    end
  end

  // Pin drive follows the pins directly so floating is immediate.
  assign serialOut        = shiftOut[7];
  assign serialOutOe      = ~selectN & pauseN & ~parLink;
  assign parallelIoBusOut = shiftOut;
  // The port is only driven while a queued byte is being returned.
  assign parallelIoBusOe  = ~selectN & pauseN & parLink & outReal;

  // Received bytes cross into the system domain.
  sfpi_async_fifo #(
    .WIDTH (sfpi_pkg::BYTE_BITS),
    .DEPTH (DEPTH)
  ) rxBuffer (
    .wrClock (serialClock),
    .wrRst   (linkRst),
    .wrValid (byteComplete),
    .wrReady (rxWrReady),
    .wrData  (rxByte),
    .rdClock (clock),
    .rdRst   (rst),
    .rdValid (rxValid),
    .rdReady (rxReady),
    .rdData  (rxData)
  );

  // Bytes to send cross into the link domain; txReady stalls the source.
  sfpi_async_fifo #(
    .WIDTH (sfpi_pkg::BYTE_BITS),
    .DEPTH (DEPTH)
  ) txBuffer (
    .wrClock (clock),
    .wrRst   (rst),
    .wrValid (txValid),
    .wrReady (txReady),
    .wrData  (txData),
    .rdClock (serialClock),
    .rdRst   (linkRst),
    .rdValid (txRdValid),
    .rdReady (byteComplete),
    .rdData  (txRdData)
  );
endmodule

// >>> tb/sfpi_pin_interface_monitor.sv
// Checker of the status outputs and pin drive enables of the pin interface.
`timescale 1ns/100ps
module sfpi_pin_interface_monitor #(
  parameter int unsigned DEPTH = sfpi_pkg::FIFO_DEPTH  // Buffer depth, handed on by the bind.
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       selectN,
  input wire logic       pauseN,
  input wire logic       serialOutOe,
  input wire logic       parallelIoBusOe,
  input wire logic       selected,
  input wire logic       standby,
  input wire logic       operationBusy,
  input wire logic       protectBoostInputN,
  input wire logic [2:0] blockProtectBits,
  input wire logic       targetInArea,
  input wire logic       programBlocked,
  input wire logic       elevatedProgramVoltage,
  input wire logic       accelProgram,
  input wire logic       rxOverrun
);
  // All checks use the system clock; pin inputs get five samples to clear their synchronisers.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_desel_float: assert property (selectN |-> !serialOutOe && !parallelIoBusOe)
    else $error("Output driven while deselected.");
  a_pause_float: assert property (!pauseN |-> !serialOutOe && !parallelIoBusOe)
    else $error("Output driven while paused.");
  a_sel_active: assert property ((!selectN)[*5] |-> selected && !standby)
    else $error("Select low but device not active.");
  a_busy_awake: assert property (operationBusy |=> !standby)
    else $error("Standby while an operation runs.");
  a_idle_standby: assert property ((selectN && !operationBusy)[*5] |-> standby)
    else $error("Idle and deselected but no standby.");
  a_block_set: assert property
    ((!protectBoostInputN && blockProtectBits != 3'h0 && targetInArea)[*5] |-> programBlocked)
    else $error("Protected target not blocked.");
  a_block_clear: assert property (protectBoostInputN[*5] |-> !programBlocked)
    else $error("Blocked while protect is high.");
  a_block_area: assert property
    (($past(blockProtectBits) == 3'h0 || !$past(targetInArea)) |-> !programBlocked)
    else $error("Blocked outside the protected area.");
  a_accel_on: assert property (elevatedProgramVoltage[*5] |-> accelProgram)
    else $error("Boost level seen but no fast programming.");
  a_accel_off: assert property ((!elevatedProgramVoltage)[*5] |-> !accelProgram)
    else $error("Fast programming without boost level.");

  // Main scenarios reached by the bench.
  c_selected: cover property (selected);
  c_blocked: cover property (programBlocked);
  c_overrun: cover property (rxOverrun);
endmodule

// >>> tb/sfpi_host_model.sv
// Host bus master model that drives the link pins of the flash interface.
`timescale 1ns/100ps
module sfpi_host_model (
  output logic      serialClock,  // Link clock, standing still between frames.
  output logic      selectN,      // Chip select, active low.
  output logic      serialIn,     // Serial data to the device.
  output logic      pauseN,       // Pause request, active low.
  input  wire logic soLine        // Resolved serial output line, z when released.
);
  // Idle pin levels at time zero.
  initial begin
    serialClock = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b0;
    pauseN = 1'b1;
  end

  // One full clock pulse of 12 ns, starting from the current level.
  task pulse();
    #6 serialClock = ~serialClock;
    #6 serialClock = ~serialClock;
  endtask

  // Select the device with the idle clock level of the chosen mode.
  task open(input logic mode3);
    serialClock = mode3;
    #20 selectN = 1'b0;
  endtask

  // Deselect, then leave the data line at the opposite of its last value.
  task close();
    #20 selectN = 1'b1;
    serialIn = ~serialIn;
  endtask

  // Shift nbits of a byte, optionally pausing before the bit at index pauseAt.
  task xfer(input logic [7:0] txb, input logic mode3, input int nbits,
            input int pauseAt, output logic [7:0] rxb);
    rxb = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      if (mode3) #6 serialClock = 1'b0;
      serialIn = txb[i];
      if (i == pauseAt) begin
        // Pause only while selected; the junk pulses must be ignored.
        #6 pauseN = 1'b0;
        repeat (3) begin
          serialIn = ~serialIn;
          pulse();
        end
        #250 serialIn = txb[i];
        pauseN = 1'b1;
      end
      #6 rxb[i] = soLine;
      serialClock = 1'b1;
      if (!mode3) #6 serialClock = 1'b0;
    end
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the serial flash pin interface.
`timescale 1ns/100ps
module tb;
  logic       clock = 1'b0, rst = 1'b1, parallelMode, rxReady, txValid;
  logic       protectBoostInputN, elevatedProgramVoltage, operationBusy;
  logic       targetInArea, serialClock, selectN, serialIn, pauseN, soLine;
  logic [2:0] blockProtectBits;
  logic [7:0] txData, hostBus, parallelIoBusIn, parallelIoBusOut, rxData;
  logic       serialOut, serialOutOe, parallelIoBusOe, rxValid, txReady, rxOverrun;
  logic       selected, standby, programBlocked, accelProgram;
  int         error_cnt = 0, check_count = 0;  // Mismatches and comparisons.

  // The host sees a floating line as z, so a released output never matches.
  assign soLine = serialOutOe ? serialOut : 1'bz;
  assign parallelIoBusIn = parallelIoBusOe ? parallelIoBusOut : hostBus;

  sfpi_pin_interface #(.DEPTH(4)) u_sfpi_pin_interface (.*);
  sfpi_host_model u_sfpi_host_model (.*);

  // System clock of 100 ns.
  always #50 clock = ~clock;

  task end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task giveUp();
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  // Offer one byte to the send buffer and wait until it is taken.
  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clock);
    txData = b;
    txValid = 1'b1;
    @(posedge clock);
    while (txReady !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (n == 40) giveUp();
    @(negedge clock);
    txValid = 1'b0;
  endtask
  // Wait for a received byte, compare it and take it.
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge clock);
    while (rxValid !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n == 40) giveUp();
    check8(rxData, exp);
    rxReady = 1'b1;
    @(negedge clock);
    rxReady = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] b, input logic m3, input logic [7:0] exp);
    logic [7:0] got;
    u_sfpi_host_model.xfer(b, m3, 8, -1, got);
    check8(got, exp);
  endtask

  // Reset with link edges for the link synchronisers, then the arming select edge.
  task automatic t_reset();
    repeat (4) u_sfpi_host_model.pulse();
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    check1(standby, 1'b1);
    u_sfpi_host_model.open(1'b0);
    repeat (5) @(negedge clock);
    repeat (2) u_sfpi_host_model.pulse();
    u_sfpi_host_model.close();
  endtask
  // Walk protect, area, boost and busy inputs, then hold select low.
  task automatic t_status();
    for (int k = 0; k < 8; k++) begin
      @(negedge clock);
      protectBoostInputN = k[0];
      operationBusy = k[0];
      targetInArea = k[1];
      blockProtectBits = k[2] ? 3'h7 : 3'h0;
      elevatedProgramVoltage = k[1] ^ k[2];
      repeat (6) @(negedge clock);
      check1(programBlocked, !k[0] && k[1] && k[2]);
      check1(accelProgram, k[1] ^ k[2]);
      check1(standby, !k[0]);
    end
    u_sfpi_host_model.open(1'b0);
    repeat (6) @(negedge clock);
    check1(selected, 1'b1);
    check1(standby, 1'b0);
    u_sfpi_host_model.close();
  endtask
  // Three serial bytes each way; the answer runs one byte behind.
  task automatic t_serial(input logic m3);
    push(8'ha5);
    push(8'h3c);
    u_sfpi_host_model.open(m3);
    sendByte(8'hc3, m3, 8'hff);
    sendByte(8'h5a, m3, 8'ha5);
    sendByte(8'h81, m3, 8'h3c);
    u_sfpi_host_model.close();
    pop(8'hc3);
    pop(8'h5a);
    pop(8'h81);
  endtask
  // A cut-off partial byte, then a byte with a pause in its middle.
  task automatic t_pause();
    logic [7:0] got;
    u_sfpi_host_model.open(1'b0);
    u_sfpi_host_model.xfer(8'he0, 1'b0, 3, -1, got);
    u_sfpi_host_model.close();
    u_sfpi_host_model.open(1'b0);
    u_sfpi_host_model.xfer(8'h42, 1'b0, 8, 4, got);
    u_sfpi_host_model.close();
    check8(got, 8'hff);
    pop(8'h42);
  endtask
  // Parallel port: capture on rise, drive after fall while a byte is queued.
  task automatic t_parallel();
    @(negedge clock);
    parallelMode = 1'b1;
    push(8'h69);
    repeat (3) u_sfpi_host_model.pulse();
    u_sfpi_host_model.open(1'b0);
    hostBus = 8'h96;
    u_sfpi_host_model.pulse();
    #1 check8(parallelIoBusOut, 8'h69);
    check1(parallelIoBusOe, 1'b1);
    u_sfpi_host_model.pulse();
    u_sfpi_host_model.close();
    hostBus = 8'h69;
    pop(8'h96);
    pop(8'h69);
    parallelMode = 1'b0;
    repeat (3) u_sfpi_host_model.pulse();
  endtask
  // Fill the send buffer to refusal, overrun the stalled receive side, drain.
  task automatic t_fifo();
    for (int k = 0; k < 4; k++) push(8'ha0 + 8'(k));
    repeat (3) @(negedge clock);
    check1(txReady, 1'b0);
    u_sfpi_host_model.open(1'b0);
    for (int k = 0; k < 6; k++) begin
      sendByte(8'h10 + 8'(k), 1'b0, (k == 0 || k == 5) ? 8'hff : 8'ha0 + 8'(k - 1));
    end
    u_sfpi_host_model.close();
    repeat (5) @(negedge clock);
    check1(rxOverrun, 1'b1);
    check1(txReady, 1'b1);
    for (int k = 0; k < 4; k++) pop(8'h10 + 8'(k));
    repeat (4) @(negedge clock);
    check1(rxValid, 1'b0);
  endtask

  // Main sequence.
  initial begin
    // Idle levels of every system-side input before reset is released.
    parallelMode = 1'b0;
    rxReady = 1'b0;
    txValid = 1'b0;
    protectBoostInputN = 1'b1;
    elevatedProgramVoltage = 1'b0;
    operationBusy = 1'b0;
    targetInArea = 1'b0;
    blockProtectBits = 3'h0;
    txData = 8'h00;
    hostBus = 8'h00;
    t_reset();
    t_status();
    t_serial(1'b0);
    t_serial(1'b1);
    t_pause();
    t_parallel();
    t_fifo();
    end_sim();
  end
endmodule

bind sfpi_pin_interface sfpi_pin_interface_monitor #(.DEPTH(DEPTH)) u_sfpi_pin_interface_monitor (.*);
